// [hdl/dprpc_pkg.sv]
// constants and types shared by the dual-port RAM port control
package dprpc_pkg;

    // ************************************************************
    // geometry
    // ************************************************************
    localparam int DPRPC_ADDR_W = 18;        // address lines, largest density
    localparam int DPRPC_LANES  = 4;         // byte lanes per word
    localparam int DPRPC_LANE_W = 9;         // bits per byte lane
    localparam int DPRPC_DATA_W = 36;        // data lines

    // ************************************************************
    // mailbox locations and reset values
    // ************************************************************
    localparam logic [17:0] DPRPC_MBX_RIGHT = 18'h3FFFF; // left writes, right reads
    localparam logic [17:0] DPRPC_MBX_LEFT  = 18'h3FFFE; // right writes, left reads
    localparam logic [17:0] DPRPC_CNT_RST   = 18'h00000; // counter after reset or clear
    localparam logic [17:0] DPRPC_MASK_RST  = 18'h3FFFF; // mask after reset
    localparam logic [35:0] DPRPC_DATA_RST  = 36'h000000000; // output register reset

    // ************************************************************
    // counter operations decoded each cycle
    // ************************************************************
    typedef enum logic [2:0] {
        DPRPC_OP_HOLD  = 3'h0,   // counter unchanged
        DPRPC_OP_LOAD  = 3'h1,   // load external address
        DPRPC_OP_INCR  = 3'h2,   // masked increment
        DPRPC_OP_CLEAR = 3'h3,   // counter to zero
        DPRPC_OP_MLOAD = 3'h4,   // load mask register
        DPRPC_OP_RBACK = 3'h5    // drive counter or mask on address
    } dprpc_op_type;

endpackage

// [hdl/dprpc_port.sv]
// per-port control: selects, counter, mask, readback and output gating
module dprpc_port
    import dprpc_pkg::*;
#(
    parameter int ADDR_W = DPRPC_ADDR_W,
    parameter int LANES  = DPRPC_LANES
) (
    // clock and master reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // host control pins
    input  wire logic              primary_select_n,
    input  wire logic              secondary_select,
    input  wire logic              read_write_n,
    input  wire logic              output_enable_n,
    input  wire logic              address_strobe_n,
    input  wire logic              counter_advance_n,
    input  wire logic              counter_clear_n,
    input  wire logic              counter_or_mask_select,
    input  wire logic [LANES-1:0]  byte_lane_enables_n,
    // address lines, two-way
    input  wire logic [ADDR_W-1:0] addr_in,
    output logic      [ADDR_W-1:0] addr_out,
    output logic                   addr_oe_n,
    // flag and data output enable
    output logic                   counter_wrap_flag_n,
    output logic                   data_oe_n,
    // access request to the array
    output logic      [ADDR_W-1:0] acc_addr,
    output logic                   acc_write,
    output logic                   acc_read,
    output logic      [LANES-1:0]  acc_lanes
);

    // ************************************************************
    // state
    // ************************************************************
    logic [ADDR_W-1:0] cnt_ff, nxt_cnt;      // address counter
    logic [ADDR_W-1:0] base_ff, nxt_base;    // last loaded address
    logic [ADDR_W-1:0] mask_ff, nxt_mask;    // wrap mask
    logic              wrap_ff, nxt_wrap;    // counter wrap flag
    logic              rd_ff, nxt_rd;        // read registered last edge
    logic              rb_ff, nxt_rb;        // readback registered last edge
    logic [ADDR_W-1:0] rbv_ff, nxt_rbv;      // readback value
    dprpc_op_type      op;                   // decoded counter operation
    logic              selected;             // both selects active
    logic              write_req;            // write asked this cycle
    logic              turn_nop;             // read-to-write turnaround
    logic [ADDR_W-1:0] inc;                  // masked increment

    // ************************************************************
    // decode of control pins
    // ************************************************************
    always_comb begin
        selected  = ~primary_select_n & secondary_select;
        write_req = selected & ~read_write_n;
        // bus still driven by a read: first write cycle is dropped
        turn_nop  = write_req & rd_ff & ~output_enable_n;
        if (!counter_clear_n) begin
            op = DPRPC_OP_CLEAR;
        end else if (counter_or_mask_select) begin
            case ({address_strobe_n, counter_advance_n})
                2'b00:   op = DPRPC_OP_LOAD;
                2'b10:   op = DPRPC_OP_INCR;
                2'b01:   op = DPRPC_OP_RBACK;
                default: op = DPRPC_OP_HOLD;
            endcase
        end else begin
            case ({address_strobe_n, counter_advance_n})
                2'b00:   op = DPRPC_OP_MLOAD;
                2'b01:   op = DPRPC_OP_RBACK;
                default: op = DPRPC_OP_HOLD;
            endcase
        end
    end

    // ************************************************************
    // access request, same cycle as any counter change
    // ************************************************************
    always_comb begin
        case (op)
            DPRPC_OP_LOAD:  acc_addr = addr_in;
            DPRPC_OP_CLEAR: acc_addr = DPRPC_CNT_RST[ADDR_W-1:0];
            default:        acc_addr = cnt_ff;
        endcase
        acc_lanes = ~byte_lane_enables_n;
        acc_write = write_req & ~turn_nop & (|acc_lanes);
        acc_read  = selected & read_write_n;
    end

    // ************************************************************
    // counter, mask, wrap flag and readback next values
    // ************************************************************
    always_comb begin
        inc      = (cnt_ff & ~mask_ff) | ((cnt_ff + 1'b1) & mask_ff);
        nxt_cnt  = cnt_ff;
        nxt_base = base_ff;
        nxt_mask = mask_ff;
        nxt_wrap = wrap_ff;
        case (op)
            DPRPC_OP_LOAD: begin
                nxt_cnt  = addr_in;
                nxt_base = addr_in;
                nxt_wrap = 1'b0;
            end
            DPRPC_OP_CLEAR: begin
                nxt_cnt  = DPRPC_CNT_RST[ADDR_W-1:0];
                nxt_base = DPRPC_CNT_RST[ADDR_W-1:0];
                nxt_wrap = 1'b0;
            end
            DPRPC_OP_INCR: begin
                // at maximum, go back to the loaded block start
                if ((cnt_ff & mask_ff) == mask_ff) begin
                    nxt_cnt = base_ff;
                end else begin
                    nxt_cnt = inc;
                end
                // flag while the unmasked part sits at maximum
                nxt_wrap = ((nxt_cnt & mask_ff) == mask_ff);
            end
            DPRPC_OP_MLOAD: begin
                nxt_mask = addr_in;
            end
            default: begin
                nxt_cnt = cnt_ff;    // hold and readback keep state
            end
        endcase
        nxt_rd  = selected & read_write_n;
        nxt_rb  = (op == DPRPC_OP_RBACK);
        nxt_rbv = counter_or_mask_select ? cnt_ff : mask_ff;
    end

    // ************************************************************
    // registers, all on the port clock edge
    // ************************************************************
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff  <= DPRPC_CNT_RST[ADDR_W-1:0];
            base_ff <= DPRPC_CNT_RST[ADDR_W-1:0];
            mask_ff <= DPRPC_MASK_RST[ADDR_W-1:0];
            wrap_ff <= 1'b0;
            rd_ff   <= 1'b0;
            rb_ff   <= 1'b0;
            rbv_ff  <= DPRPC_CNT_RST[ADDR_W-1:0];
        end else begin
            cnt_ff  <= nxt_cnt;
            base_ff <= nxt_base;
            mask_ff <= nxt_mask;
            wrap_ff <= nxt_wrap;
            rd_ff   <= nxt_rd;
            rb_ff   <= nxt_rb;
            rbv_ff  <= nxt_rbv;
        end
    end

    // ************************************************************
    // pin drivers; enables are low while driving
    // ************************************************************
    always_comb begin
        counter_wrap_flag_n = ~wrap_ff;
        addr_out            = rbv_ff;
        addr_oe_n           = ~rb_ff;
        // enable is asynchronous, the read state is registered
        data_oe_n           = ~(rd_ff & ~output_enable_n);
    end

endmodule

// [hdl/dprpc_top.sv]
// dual-port RAM core: array, byte-lane writes, read pipeline, mailboxes
module dprpc_top
    import dprpc_pkg::*;
#(
    parameter int ADDR_W = DPRPC_ADDR_W,
    parameter int LANES  = DPRPC_LANES,
    parameter int LANE_W = DPRPC_LANE_W,
    parameter int DATA_W = DPRPC_DATA_W
) (
    // clock and master reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // left port controls
    input  wire logic              left_primary_select_n,
    input  wire logic              left_secondary_select,
    input  wire logic              left_read_write_n,
    input  wire logic              left_output_enable_n,
    input  wire logic              left_address_strobe_n,
    input  wire logic              left_counter_advance_n,
    input  wire logic              left_counter_clear_n,
    input  wire logic              left_counter_or_mask_select,
    input  wire logic [LANES-1:0]  left_byte_lane_enables_n,
    // left port address lines
    input  wire logic [ADDR_W-1:0] left_addr_in,
    output logic      [ADDR_W-1:0] left_addr_out,
    output logic                   left_addr_oe_n,
    // left port data lines
    input  wire logic [DATA_W-1:0] left_data_lines_in,
    output logic      [DATA_W-1:0] left_data_lines_out,
    output logic                   left_data_lines_oe_n,
    // left port flags
    output logic                   left_counter_wrap_flag_n,
    output logic                   left_mailbox_flag_n,
    // right port controls
    input  wire logic              right_primary_select_n,
    input  wire logic              right_secondary_select,
    input  wire logic              right_read_write_n,
    input  wire logic              right_output_enable_n,
    input  wire logic              right_address_strobe_n,
    input  wire logic              right_counter_advance_n,
    input  wire logic              right_counter_clear_n,
    input  wire logic              right_counter_or_mask_select,
    input  wire logic [LANES-1:0]  right_byte_lane_enables_n,
    // right port address lines
    input  wire logic [ADDR_W-1:0] right_addr_in,
    output logic      [ADDR_W-1:0] right_addr_out,
    output logic                   right_addr_oe_n,
    // right port data lines
    input  wire logic [DATA_W-1:0] right_data_lines_in,
    output logic      [DATA_W-1:0] right_data_lines_out,
    output logic                   right_data_lines_oe_n,
    // right port flags
    output logic                   right_counter_wrap_flag_n,
    output logic                   right_mailbox_flag_n
);

    // ************************************************************
    // storage and per-port wiring, index 0 left, 1 right
    // ************************************************************
    localparam int DEPTH = 1 << ADDR_W;      // words in the array

    logic [DATA_W-1:0] mem_ff [DEPTH];       // shared array
    logic [ADDR_W-1:0] acc_addr  [2];        // access address per port
    logic              acc_write [2];        // accepted write per port
    logic              acc_read  [2];        // read request per port
    logic [LANES-1:0]  acc_lanes [2];        // active lanes per port
    logic [DATA_W-1:0] wdata     [2];        // sampled write data
    logic [DATA_W-1:0] rdata_ff  [2];        // registered read data
    logic [DATA_W-1:0] nxt_rdata [2];        // next read data
    logic              mbx_r_ff, nxt_mbx_r;  // flag toward right port
    logic              mbx_l_ff, nxt_mbx_l;  // flag toward left port
    logic              l_wr_top, r_wr_top;   // writes to mailbox words
    logic              l_rd_top, r_rd_top;   // reads of mailbox words

    // ************************************************************
    // left port control
    // ************************************************************
    dprpc_port #(
        .ADDR_W (ADDR_W),
        .LANES  (LANES)
    ) u_left (
        .clk                    (clk),
        .resetn                 (resetn),
        .primary_select_n       (left_primary_select_n),
        .secondary_select       (left_secondary_select),
        .read_write_n           (left_read_write_n),
        .output_enable_n        (left_output_enable_n),
        .address_strobe_n       (left_address_strobe_n),
        .counter_advance_n      (left_counter_advance_n),
        .counter_clear_n        (left_counter_clear_n),
        .counter_or_mask_select (left_counter_or_mask_select),
        .byte_lane_enables_n    (left_byte_lane_enables_n),
        .addr_in                (left_addr_in),
        .addr_out               (left_addr_out),
        .addr_oe_n              (left_addr_oe_n),
        .counter_wrap_flag_n    (left_counter_wrap_flag_n),
        .data_oe_n              (left_data_lines_oe_n),
        .acc_addr               (acc_addr[0]),
        .acc_write              (acc_write[0]),
        .acc_read               (acc_read[0]),
        .acc_lanes              (acc_lanes[0])
    );

    // ************************************************************
    // right port control
    // ************************************************************
    dprpc_port #(
        .ADDR_W (ADDR_W),
        .LANES  (LANES)
    ) u_right (
        .clk                    (clk),
        .resetn                 (resetn),
        .primary_select_n       (right_primary_select_n),
        .secondary_select       (right_secondary_select),
        .read_write_n           (right_read_write_n),
        .output_enable_n        (right_output_enable_n),
        .address_strobe_n       (right_address_strobe_n),
        .counter_advance_n      (right_counter_advance_n),
        .counter_clear_n        (right_counter_clear_n),
        .counter_or_mask_select (right_counter_or_mask_select),
        .byte_lane_enables_n    (right_byte_lane_enables_n),
        .addr_in                (right_addr_in),
        .addr_out               (right_addr_out),
        .addr_oe_n              (right_addr_oe_n),
        .counter_wrap_flag_n    (right_counter_wrap_flag_n),
        .data_oe_n              (right_data_lines_oe_n),
        .acc_addr               (acc_addr[1]),
        .acc_write              (acc_write[1]),
        .acc_read               (acc_read[1]),
        .acc_lanes              (acc_lanes[1])
    );

    // ************************************************************
    // write data gathered per port
    // ************************************************************
    always_comb begin
        wdata[0] = left_data_lines_in;   // sampled at the same edge as address
        wdata[1] = right_data_lines_in;
    end

    // ************************************************************
    // array writes, byte lanes only; right wins a same-word clash
    // ************************************************************
    always_ff @(posedge clk) begin
        for (int p = 0; p < 2; p++) begin
            for (int b = 0; b < LANES; b++) begin
                // untouched lanes keep their old contents
                if (acc_write[p] && acc_lanes[p][b]) begin
                    mem_ff[acc_addr[p]][b*LANE_W +: LANE_W] <=
                        wdata[p][b*LANE_W +: LANE_W];
                end
            end
        end
    end

    // ************************************************************
    // read pipeline: data captured at the request edge
    // ************************************************************
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            // old word seen here; a same-edge write from the far side
            // shows on the reader's next access
            if (acc_read[p]) begin
                nxt_rdata[p] = mem_ff[acc_addr[p]];
            end else begin
                nxt_rdata[p] = rdata_ff[p];         // hold last word
            end
        end
    end

    // read data registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff[0] <= DPRPC_DATA_RST[DATA_W-1:0];
            rdata_ff[1] <= DPRPC_DATA_RST[DATA_W-1:0];
        end else begin
            rdata_ff[0] <= nxt_rdata[0];
            rdata_ff[1] <= nxt_rdata[1];
        end
    end

    // data outputs come straight from the read registers
    always_comb begin
        left_data_lines_out  = rdata_ff[0];
        right_data_lines_out = rdata_ff[1];
    end

    // ************************************************************
    // mailbox detection; a byte lane must be active to count
    // ************************************************************
    always_comb begin
        l_wr_top = acc_write[0] && (acc_addr[0] == DPRPC_MBX_RIGHT[ADDR_W-1:0]);
        r_wr_top = acc_write[1] && (acc_addr[1] == DPRPC_MBX_LEFT[ADDR_W-1:0]);
        l_rd_top = acc_read[0] && (|acc_lanes[0]) &&
                   (acc_addr[0] == DPRPC_MBX_LEFT[ADDR_W-1:0]);
        r_rd_top = acc_read[1] && (|acc_lanes[1]) &&
                   (acc_addr[1] == DPRPC_MBX_RIGHT[ADDR_W-1:0]);
    end

    // ************************************************************
    // mailbox flags: writer sets, reader clears, set wins
    // ************************************************************
    always_comb begin
        nxt_mbx_r = (mbx_r_ff & ~r_rd_top) | l_wr_top;
        nxt_mbx_l = (mbx_l_ff & ~l_rd_top) | r_wr_top;
    end

    // mailbox flag registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mbx_r_ff <= 1'b0;
            mbx_l_ff <= 1'b0;
        end else begin
            mbx_r_ff <= nxt_mbx_r;
            mbx_l_ff <= nxt_mbx_l;
        end
    end

    // mailbox flags drive low when raised
    always_comb begin
        right_mailbox_flag_n = ~mbx_r_ff;
        left_mailbox_flag_n  = ~mbx_l_ff;
    end

endmodule

// [tb/dprpc_host.sv]
// host-side model of one port's two-way address lines
module dprpc_host (
    // host request and device readback
    input  logic [17:0] host_addr,
    input  logic [17:0] addr_out,
    input  logic        addr_oe_n,
    // resolved address lines seen by the device
    output logic [17:0] addr_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // host lets go while the device drives the lines
    assign addr_in = addr_oe_n ? host_addr : addr_out;
endmodule

// [tb/dprpc_asserts.sv]
// concurrent checks on the left port and the right mailbox flag
module dprpc_chk
    import dprpc_pkg::*;
#(
    parameter int ADDR_W = DPRPC_ADDR_W,
    parameter int LANES  = DPRPC_LANES
) (
    // clock and master reset
    input logic              clk,
    input logic              resetn,
    // left port controls
    input logic              left_primary_select_n,
    input logic              left_secondary_select,
    input logic              left_read_write_n,
    input logic              left_output_enable_n,
    input logic              left_address_strobe_n,
    input logic              left_counter_advance_n,
    input logic              left_counter_clear_n,
    input logic              left_counter_or_mask_select,
    input logic [LANES-1:0]  left_byte_lane_enables_n,
    input logic [ADDR_W-1:0] left_addr_in,
    // observed outputs
    input logic              left_addr_oe_n,
    input logic              left_data_lines_oe_n,
    input logic              left_counter_wrap_flag_n,
    input logic              right_mailbox_flag_n
);
    timeunit 1ns;
    timeprecision 1ps;
    wire sel = !left_primary_select_n && left_secondary_select; // both selects active
    wire ld = !left_address_strobe_n && !left_counter_advance_n && left_counter_clear_n;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_rd_drive;
        sel && left_read_write_n |=> left_output_enable_n || !left_data_lines_oe_n;
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
    property p_desel;
        !sel |=> left_data_lines_oe_n;
    endproperty
    a_desel: assert property (p_desel) else $error("deselect kept data");
    property p_oe_float;
        left_output_enable_n |-> left_data_lines_oe_n;
    endproperty
    a_oe_float: assert property (p_oe_float) else $error("data driven with oe high");
    property p_rback;
        sel && !left_address_strobe_n && left_counter_advance_n && left_counter_clear_n
            |=> !left_addr_oe_n;
    endproperty
    a_rback: assert property (p_rback) else $error("readback not driven");
    property p_clr_wrap;
        !left_counter_clear_n |=> left_counter_wrap_flag_n;
    endproperty
    a_clr_wrap: assert property (p_clr_wrap) else $error("wrap flag after clear");
    property p_wrap_idle;
        left_address_strobe_n && left_counter_advance_n && left_counter_clear_n
            |=> $stable(left_counter_wrap_flag_n);
    endproperty
    a_wrap_idle: assert property (p_wrap_idle) else $error("wrap flag moved on hold");
    property p_mbx_set;
        sel && ld && left_counter_or_mask_select && !left_read_write_n
            && left_byte_lane_enables_n != '1 && left_addr_in == DPRPC_MBX_RIGHT
            && left_data_lines_oe_n |=> !right_mailbox_flag_n;
    endproperty
    a_mbx_set: assert property (p_mbx_set) else $error("mailbox not raised");
    property p_rst_flag;
        @(posedge clk) disable iff (1'b0) !resetn |-> left_counter_wrap_flag_n;
    endproperty
    a_rst_flag: assert property (p_rst_flag) else $error("wrap flag in reset");
    c_rback: cover property (!left_addr_oe_n);
    c_wrap: cover property ($fell(left_counter_wrap_flag_n));
    c_mbx: cover property ($fell(right_mailbox_flag_n));
endmodule
bind dprpc_top dprpc_chk #(.ADDR_W(ADDR_W), .LANES(LANES)) u_chk (.*);

// [tb/dual_port_ram_port_control_test.sv]
// self-checking bench for the dual-port RAM port control
module dual_port_ram_port_control_test
    import dprpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // control words: selects, rw, oe, strobe, advance, clear, cnt/mask, lanes
    localparam logic [11:0] IDLE = 12'hBFF, RD = 12'h630, WR = 12'h530, WRP = 12'h53A;
    localparam logic [11:0] WRO = 12'h430, RDC = 12'h610, INC = 12'h6B0, RBC = 12'h670;
    localparam logic [11:0] RBM = 12'h660, MLD = 12'h620;
    logic left_primary_select_n, left_secondary_select, left_read_write_n;
    logic left_output_enable_n, left_address_strobe_n, left_counter_advance_n;
    logic left_counter_clear_n, left_counter_or_mask_select;
    logic right_primary_select_n, right_secondary_select, right_read_write_n;
    logic right_output_enable_n, right_address_strobe_n, right_counter_advance_n;
    logic right_counter_clear_n, right_counter_or_mask_select;
    logic [3:0] left_byte_lane_enables_n, right_byte_lane_enables_n;
    logic [17:0] left_addr_in, left_addr_out, right_addr_in, right_addr_out;
    logic [17:0] left_host_addr, right_host_addr;
    logic [35:0] left_data_lines_in, left_data_lines_out;
    logic [35:0] right_data_lines_in, right_data_lines_out;
    logic left_addr_oe_n, right_addr_oe_n, left_data_lines_oe_n, right_data_lines_oe_n;
    logic clk, resetn, left_counter_wrap_flag_n, left_mailbox_flag_n;
    logic right_counter_wrap_flag_n, right_mailbox_flag_n;
    int mismatches = 0, num_checks = 0;
    dprpc_top u_dut (.*);
    dprpc_host u_lhost (.host_addr(left_host_addr), .addr_out(left_addr_out),
        .addr_oe_n(left_addr_oe_n), .addr_in(left_addr_in));
    dprpc_host u_rhost (.host_addr(right_host_addr), .addr_out(right_addr_out),
        .addr_oe_n(right_addr_oe_n), .addr_in(right_addr_in));
    always #5 clk = ~clk;
    task automatic chk(string n, logic [35:0] e, logic [35:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // left port cycle, driven at the falling edge
    task automatic lset(logic [11:0] c, logic [17:0] a, logic [35:0] d);
        {left_primary_select_n, left_secondary_select, left_read_write_n,
         left_output_enable_n, left_address_strobe_n, left_counter_advance_n,
         left_counter_clear_n, left_counter_or_mask_select, left_byte_lane_enables_n} = c;
        left_host_addr = a;
        left_data_lines_in = d;
        @(negedge clk);
    endtask
    // right port controls, applied with the next left cycle
    task automatic rset(logic [11:0] c, logic [17:0] a);
        {right_primary_select_n, right_secondary_select, right_read_write_n,
         right_output_enable_n, right_address_strobe_n, right_counter_advance_n,
         right_counter_clear_n, right_counter_or_mask_select, right_byte_lane_enables_n} = c;
        right_host_addr = a;
    endtask
    task automatic t_rw();
        lset(WR, 18'h00005, 36'h000000000);
        lset(WRP, 18'h00005, 36'hFFFFFFFFF);
        lset(RD, 18'h00005, 36'h0);
        chk("merged word", 36'h007FC01FF, left_data_lines_out);
        chk("read drive", 1'b0, left_data_lines_oe_n);
    endtask
    task automatic t_turn();
        lset(WRO, 18'h00005, 36'hAAAAAAAAA);
        lset(RD, 18'h00005, 36'h0);
        chk("no-op kept word", 36'h007FC01FF, left_data_lines_out);
        lset(WRO, 18'h00005, 36'hBBBBBBBBB);
        lset(WRO, 18'h00005, 36'hBBBBBBBBB);
        lset(RD, 18'h00005, 36'h0);
        chk("rewritten word", 36'hBBBBBBBBB, left_data_lines_out);
    endtask
    task automatic t_desel();
        left_primary_select_n = 1'b1;
        #1 chk("drive before edge", 1'b0, left_data_lines_oe_n);
        @(negedge clk);
        chk("float after edge", 1'b1, left_data_lines_oe_n);
        lset(RD, 18'h00005, 36'h0);
        left_output_enable_n = 1'b1;
        #1 chk("oe float", 1'b1, left_data_lines_oe_n);
        @(negedge clk);
    endtask
    task automatic t_clear();
        lset(WR, 18'h00000, 36'h0000000C3);
        lset(RDC, 18'h00007, 36'h0);
        chk("clear read", 36'h0000000C3, left_data_lines_out);
    endtask
    task automatic t_rback();
        lset(RD, 18'h00123, 36'h0);
        lset(MLD, 18'h00003, 36'h0);
        lset(RBC, 18'h00000, 36'h0);
        chk("counter readback", 18'h00123, left_addr_out);
        lset(RBM, 18'h00000, 36'h0);
        chk("mask readback", 18'h00003, left_addr_out);
        lset(IDLE, 18'h0, 36'h0);
        chk("address float", 1'b1, left_addr_oe_n);
    endtask
    task automatic t_wrap();
        lset(RD, 18'h3FFFD, 36'h0);
        lset(INC, 18'h0, 36'h0);
        lset(INC, 18'h0, 36'h0);
        chk("wrap flag", 1'b0, left_counter_wrap_flag_n);
        lset(INC, 18'h0, 36'h0);
        chk("wrap flag off", 1'b1, left_counter_wrap_flag_n);
        lset(RBC, 18'h0, 36'h0);
        chk("retransmit start", 18'h3FFFD, left_addr_out);
        lset(INC, 18'h0, 36'h0);
        lset(INC, 18'h0, 36'h0);
        resetn = 1'b0;
        #1 chk("reset clears flag", 1'b1, left_counter_wrap_flag_n);
        @(negedge clk);
        resetn = 1'b1;
    endtask
    task automatic t_mbx();
        rset(RD, 18'h00009);
        lset(WR, 18'h00009, 36'h0000000A5);
        lset(WR, DPRPC_MBX_RIGHT, 36'h0);
        chk("cross port data", 36'h0000000A5, right_data_lines_out);
        chk("mailbox raised", 1'b0, right_mailbox_flag_n);
        rset(RD, DPRPC_MBX_RIGHT);
        lset(IDLE, 18'h0, 36'h0);
        chk("mailbox cleared", 1'b1, right_mailbox_flag_n);
        rset(WR, DPRPC_MBX_LEFT);
        lset(IDLE, 18'h0, 36'h0);
        chk("left mbx set", 1'b0, left_mailbox_flag_n);
        rset(IDLE, 18'h0);
        lset(RD, DPRPC_MBX_LEFT, 36'h0);
        chk("left mbx clr", 1'b1, left_mailbox_flag_n);
    endtask
    task automatic report_and_stop();
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watchdog, far beyond the test length
    initial begin
        #5000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        right_data_lines_in = '0;
        rset(IDLE, 18'h0);
        lset(IDLE, 18'h0, 36'h0);
        repeat (11) @(negedge clk);
        resetn = 1'b1;
        chk("flag after reset", 1'b1, left_counter_wrap_flag_n);
        t_rw();
        t_turn();
        t_desel();
        t_clear();
        t_rback();
        t_wrap();
        t_mbx();
        report_and_stop();
    end
endmodule
